//--- src/counter_array.v
// five-module capture/compare counter array with shared 16-bit time base
`include "counter_array_consts.vh"

module counter_array (
  input wire clk,
  input wire sys_rst,
  input wire [7:0] sfr_addr,
  input wire [7:0] sfr_wdata,
  input wire sfr_wr,
  input wire sfr_rd,
  output reg [7:0] sfr_rdata_r,
  input wire cpu_idle,
  input wire timer0_overflow,
  input wire external_count_input,
  input wire [4:0] module_pin_in,
  output reg [4:0] module_pin_r,
  output reg [5:0] pin_claim_r,
  output reg irq_r,
  output reg watchdog_reset_r
);

  reg [7:0] counter_mode_r;
  reg run_r;
  reg overflow_flag_r;
  reg [4:0] event_flag_r;
  reg [15:0] count_r;
  reg [2:0] prescale_r;
  reg [6:0] module_mode_r [0:4];
  reg [7:0] value_low_r [0:4];
  reg [7:0] value_high_r [0:4];
  reg [5:0] sync1_r;
  reg [5:0] sync2_r;
  reg [5:0] sync3_r;
  reg [5:0] pin_claim_nxt;
  reg [4:0] pin_nxt;
  reg [4:0] flag_nxt;
  reg [4:0] match_w;
  reg [4:0] capture_w;
  reg [7:0] rdata_nxt;
  reg tick;
  reg halted;
  reg [15:0] count_nxt;
  reg [4:0] pwm_on; // per module: pwm bit and compare enable both set
  reg [4:0] irq_enables; // per module flag interrupt enables, gathered
  reg counter_wrap; // tick taken while the counter stands at all ones
  integer i;

  // true when addr hits the per-module register group at base
  function hit;
    input [7:0] addr;
    input [7:0] base;
    input integer n;
    begin
      hit = (addr == base + n[7:0]);
    end
  endfunction

  // rising/falling edge on a synchronised line
  function edge_seen;
    input prev;
    input cur;
    input rise_en;
    input fall_en;
    begin
      edge_seen = (rise_en & ~prev & cur) | (fall_en & prev & ~cur);
    end
  endfunction

  // count source field of the mode register; read by the tick mux and
  // by the pin claim, so both always agree on which source is live
  function [1:0] src_of;
    input [7:0] mode;
    begin
      src_of = {mode[`MODE_SRC_HI], mode[`MODE_SRC_LO]};
    end
  endfunction

  // pwm needs both its own bit and the comparator enable
  function pwm_mode;
    input [6:0] mm;
    begin
      pwm_mode = mm[`MM_PWM_EN] & mm[`MM_COMPARE_EN];
    end
  endfunction

  // timing notes for users of this block:
  // - a compare match is seen on the tick that moves the counter onto
  //   the module value, so a value written equal to a frozen count
  //   never matches until the counter comes round again
  // - captures take the counter as it stood before the edge's tick,
  //   three clocks after the pin moved (two sync stages plus compare)
  // - the counter bytes are separate registers with no latch, so a
  //   running counter read as two bytes may tear across a carry
  // - the watchdog request is internal only and lasts one clock

  // tick generation and halt condition
  always @* begin
    halted = ~run_r | (counter_mode_r[`MODE_IDLE_STOP] & cpu_idle);
    case (src_of(counter_mode_r))
      `SRC_DIV6: tick = (prescale_r == `DIV6_LAST);
      `SRC_DIV2: tick = prescale_r[0];
      `SRC_TIMER0: tick = timer0_overflow;
      `SRC_EXT: tick = ~sync3_r[5] & sync2_r[5];
      default: tick = 1'b0;
    endcase
    tick = tick & ~halted;
    count_nxt = tick ? count_r + `COUNT_STEP : count_r;
    // wrap from all ones to zero is the overflow event
    counter_wrap = tick & (count_r == `COUNTER_ALL_ONES);
  end

  // module compare and capture decode, all against the single counter
  always @* begin
    for (i = 0; i < `NUM_MODULES; i = i + 1) begin
      match_w[i] = module_mode_r[i][`MM_COMPARE_EN] & tick &
        (count_nxt == {value_high_r[i], value_low_r[i]});
      capture_w[i] = edge_seen(sync3_r[i], sync2_r[i],
        module_mode_r[i][`MM_RISE_CAP], module_mode_r[i][`MM_FALL_CAP]);
      pwm_on[i] = pwm_mode(module_mode_r[i]);
      irq_enables[i] = module_mode_r[i][`MM_IRQ_EN];
    end
  end

  // next values for pins, flags and pin claims
  always @* begin
    for (i = 0; i < `NUM_MODULES; i = i + 1) begin
      pin_nxt[i] = module_pin_r[i];
      if (pwm_on[i]) begin
        pin_nxt[i] = (count_r[7:0] >= value_low_r[i]);
      end else if (match_w[i] & module_mode_r[i][`MM_TOGGLE_EN] &
          module_mode_r[i][`MM_MATCH_EN]) begin
        pin_nxt[i] = ~module_pin_r[i];
      end
      flag_nxt[i] = (match_w[i] & module_mode_r[i][`MM_MATCH_EN]) | capture_w[i];
      pin_claim_nxt[i + 1] = |module_mode_r[i][`MM_RISE_CAP:`MM_PWM_EN];
    end
    pin_claim_nxt[0] = (src_of(counter_mode_r) == `SRC_EXT);
  end

  // register read mux; unmapped reads return zero
  always @* begin
    rdata_nxt = `RESET_BYTE;
    if (sfr_addr == `ADDR_COUNTER_MODE)
      rdata_nxt = counter_mode_r;
    if (sfr_addr == `ADDR_COUNTER_CONTROL)
      rdata_nxt = {overflow_flag_r, run_r, 1'b0, event_flag_r};
    if (sfr_addr == `ADDR_COUNTER_LOW)
      rdata_nxt = count_r[7:0];
    if (sfr_addr == `ADDR_COUNTER_HIGH)
      rdata_nxt = count_r[15:8];
    for (i = 0; i < `NUM_MODULES; i = i + 1) begin
      if (hit(sfr_addr, `ADDR_MODULE_MODE0, i))
        rdata_nxt = {1'b0, module_mode_r[i]};
      if (hit(sfr_addr, `ADDR_MODULE_VALUE_LOW0, i))
        rdata_nxt = value_low_r[i];
      if (hit(sfr_addr, `ADDR_MODULE_VALUE_HIGH0, i))
        rdata_nxt = value_high_r[i];
    end
  end

  // synchronisers: stage 1 feeds only stage 2; they reset to the idle-high
  // pin level so a quiet pin shows no false rising edge after reset
  always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      sync1_r <= `SYNC_IDLE;
      sync2_r <= `SYNC_IDLE;
      sync3_r <= `SYNC_IDLE;
    end else begin
      sync1_r <= {external_count_input, module_pin_in};
      sync2_r <= sync1_r;
      sync3_r <= sync2_r;
    end
  end

  // prescaler free-runs while counting so div2 and div6 stay in phase;
  // a halt parks it at zero so a restart always begins a whole period
  always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      prescale_r <= `PRESCALE_RESET;
    end else if (halted | (prescale_r == `DIV6_LAST)) begin
      prescale_r <= `PRESCALE_RESET;
    end else begin
      prescale_r <= prescale_r + `PRESCALE_STEP;
    end
  end

  // the one shared counter; a byte write beats a same-cycle tick on that
  // byte only, the other byte still takes the incremented value
  always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      count_r <= `COUNT_RESET;
    end else begin
      count_r <= count_nxt;
      if (sfr_wr & (sfr_addr == `ADDR_COUNTER_LOW))
        count_r[7:0] <= sfr_wdata;
      if (sfr_wr & (sfr_addr == `ADDR_COUNTER_HIGH))
        count_r[15:8] <= sfr_wdata;
    end
  end

  // mode register and run bit
  always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      counter_mode_r <= `RESET_BYTE;
      run_r <= 1'b0;
    end else if (sfr_wr) begin
      if (sfr_addr == `ADDR_COUNTER_MODE)
        counter_mode_r <= sfr_wdata & `MODE_WRITABLE; // reserved bits held at zero
      if (sfr_addr == `ADDR_COUNTER_CONTROL)
        run_r <= sfr_wdata[`CTRL_RUN];
    end
  end

  // status flags: hardware set wins over a same-cycle software clear, so
  // an event landing on the clearing write is never lost
  always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      overflow_flag_r <= 1'b0;
      event_flag_r <= `FLAGS_RESET;
    end else begin
      if (counter_wrap)
        overflow_flag_r <= 1'b1;
      else if (sfr_wr & (sfr_addr == `ADDR_COUNTER_CONTROL))
        overflow_flag_r <= sfr_wdata[`CTRL_OVF_FLAG];
      event_flag_r <= (sfr_wr & (sfr_addr == `ADDR_COUNTER_CONTROL) ?
        sfr_wdata[`CTRL_FLAGS_MSB:0] : event_flag_r) | flag_nxt;
    end
  end

  // module registers: mode, compare/capture values, pwm reload
  always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      for (i = 0; i < `NUM_MODULES; i = i + 1) begin
        module_mode_r[i] <= `MODULE_MODE_RESET;
        value_low_r[i] <= `RESET_BYTE;
        value_high_r[i] <= `RESET_BYTE;
      end
    end else begin
      for (i = 0; i < `NUM_MODULES; i = i + 1) begin
        if (sfr_wr & hit(sfr_addr, `ADDR_MODULE_MODE0, i))
          module_mode_r[i] <= sfr_wdata[`MM_MSB:0];
        if (sfr_wr & hit(sfr_addr, `ADDR_MODULE_VALUE_LOW0, i))
          value_low_r[i] <= sfr_wdata;
        if (sfr_wr & hit(sfr_addr, `ADDR_MODULE_VALUE_HIGH0, i))
          value_high_r[i] <= sfr_wdata;
        // duty reload only at wrap so a period never sees a half update
        if (pwm_on[i] & tick & (count_r[7:0] == `LOW_BYTE_ALL_ONES))
          value_low_r[i] <= value_high_r[i];
        if (capture_w[i]) begin
          value_low_r[i] <= count_r[7:0];
          value_high_r[i] <= count_r[15:8];
        end
      end
    end
  end

  // registered outputs
  always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      module_pin_r <= `PIN_IDLE;
      pin_claim_r <= `CLAIM_RESET;
      irq_r <= 1'b0;
      watchdog_reset_r <= 1'b0;
      sfr_rdata_r <= `RESET_BYTE;
    end else begin
      module_pin_r <= pin_nxt;
      pin_claim_r <= pin_claim_nxt;
      // one shared line for the overflow and all five module sources
      irq_r <= (overflow_flag_r & counter_mode_r[`MODE_OVF_IRQ_EN]) |
        (|(event_flag_r & irq_enables));
      // internal reset only; the external reset pin is not touched here
      watchdog_reset_r <= counter_mode_r[`MODE_WATCHDOG_EN] &
        match_w[`WATCHDOG_MODULE];
      if (sfr_rd)
        sfr_rdata_r <= rdata_nxt;
    end
  end

endmodule // counter_array

//--- shared/counter_array_consts.vh
// register addresses, field positions and reset values of the counter array
`ifndef COUNTER_ARRAY_CONSTS_VH
`define COUNTER_ARRAY_CONSTS_VH
`define ADDR_COUNTER_MODE 8'hd9
`define ADDR_COUNTER_CONTROL 8'hd8
`define ADDR_MODULE_MODE0 8'hda
`define ADDR_MODULE_VALUE_LOW0 8'hea
`define ADDR_MODULE_VALUE_HIGH0 8'hfa
`define ADDR_COUNTER_LOW 8'he9
`define ADDR_COUNTER_HIGH 8'hf9
`define NUM_MODULES 5
`define WATCHDOG_MODULE 4
`define MODE_IDLE_STOP 7
`define MODE_WATCHDOG_EN 6
`define MODE_SRC_HI 2
`define MODE_SRC_LO 1
`define MODE_OVF_IRQ_EN 0
`define CTRL_OVF_FLAG 7
`define CTRL_RUN 6
`define MM_COMPARE_EN 6
`define MM_RISE_CAP 5
`define MM_FALL_CAP 4
`define MM_MATCH_EN 3
`define MM_TOGGLE_EN 2
`define MM_PWM_EN 1
`define MM_IRQ_EN 0
`define SRC_DIV6 2'h0
`define SRC_DIV2 2'h1
`define SRC_TIMER0 2'h2
`define SRC_EXT 2'h3
`define DIV6_LAST 3'h5
`define RESET_BYTE 8'h00
`define COUNTER_ALL_ONES 16'hffff
`define LOW_BYTE_ALL_ONES 8'hff
`define COUNT_RESET 16'h0000
`define COUNT_STEP 16'h0001
`define PRESCALE_RESET 3'h0
`define PRESCALE_STEP 3'h1
`define MODULE_MODE_RESET 7'h00
`define MM_MSB 6
`define FLAGS_RESET 5'h00
`define CTRL_FLAGS_MSB 4
`define PIN_IDLE 5'h1f
`define SYNC_IDLE 6'h3f
`define CLAIM_RESET 6'h00
`define MODE_WRITABLE 8'hc7
`endif

//--- test/timer0_model.sv
// timer 0 overflow source standing at the far side of the counter array
module timer0_model (
  input wire logic clk,
  input wire logic en,
  output logic ovf,
  output logic [7:0] sent
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [1:0] div;
  initial begin
    div = 2'h0;
    ovf = 1'b0;
    sent = 8'h00;
  end
  // one pulse every third cycle; the count lets the bench predict the counter
  always @(posedge clk) begin
    div <= (en && div != 2'h2) ? div + 2'h1 : 2'h0;
    ovf <= en && div == 2'h2;
    sent <= sent + {7'h00, en && div == 2'h2};
  end
endmodule // timer0_model

//--- test/counter_array_assertions.sv
// port-level checks of the counter array
module counter_array_checker (
  input wire clk,
  input wire sys_rst,
  input wire [7:0] sfr_addr,
  input wire [7:0] sfr_wdata,
  input wire sfr_wr,
  input wire sfr_rd,
  input wire [7:0] sfr_rdata_r,
  input wire [4:0] module_pin_r,
  input wire [5:0] pin_claim_r,
  input wire irq_r,
  input wire watchdog_reset_r
);
  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);
  // mode writes that claim or release pins
  sequence ext_src_wr;
    sfr_wr && sfr_addr == 8'hd9 && sfr_wdata[2:1] == 2'h3;
  endsequence
  sequence mod0_off_wr;
    sfr_wr && sfr_addr == 8'hda && sfr_wdata[5:1] == 5'h00;
  endsequence
  rd_hold_a: assert property (!sfr_rd |=> $stable(sfr_rdata_r))
    else $error("read data moved without a read");
  mode_resv_a: assert property (sfr_rd && sfr_addr == 8'hd9 |=> sfr_rdata_r[5:3] == 3'h0)
    else $error("mode reserved bits not zero");
  unmapped_rd_a: assert property (sfr_rd && sfr_addr == 8'h00 |=> sfr_rdata_r == 8'h00)
    else $error("unmapped read not zero");
  wd_pulse_a: assert property (watchdog_reset_r |=> !watchdog_reset_r)
    else $error("watchdog reset longer than one cycle");
  irq_fall_a: assert property ($fell(irq_r) |-> $past(sfr_wr) || $past(sfr_wr, 2))
    else $error("irq dropped with no write");
  claim_src_a: assert property (ext_src_wr |-> ##[1:3] pin_claim_r[0])
    else $error("count pin not claimed");
  claim_free_a: assert property (mod0_off_wr |-> ##[1:3] !pin_claim_r[1])
    else $error("module 0 pin not released");
  // module 4 never toggles while it claims no pin mode
  pin_idle_a: assert property (!pin_claim_r[5] ##1 !pin_claim_r[5] |-> $stable(module_pin_r[4]))
    else $error("unclaimed module pin moved");
endmodule // counter_array_checker
bind counter_array counter_array_checker counter_array_checker_inst (.*);

//--- test/tb_top.sv
// self-checking bench for the counter array
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk, sys_rst, sfr_wr, sfr_rd, cpu_idle, ext_in, t0_en, t0_ovf, irq_r, wd;
  logic [7:0] sfr_addr, sfr_wdata, sfr_rdata_r, sent;
  logic [4:0] pin_in, module_pin_r;
  logic [5:0] pin_claim_r;
  int n_fail, check_count, i;
  logic wd_seen;
  counter_array counter_array_inst (.clk(clk), .sys_rst(sys_rst), .sfr_addr(sfr_addr),
    .sfr_wdata(sfr_wdata), .sfr_wr(sfr_wr), .sfr_rd(sfr_rd), .sfr_rdata_r(sfr_rdata_r),
    .cpu_idle(cpu_idle), .timer0_overflow(t0_ovf), .external_count_input(ext_in),
    .module_pin_in(pin_in), .module_pin_r(module_pin_r), .pin_claim_r(pin_claim_r),
    .irq_r(irq_r), .watchdog_reset_r(wd));
  timer0_model timer0_model_inst (.clk(clk), .en(t0_en), .ovf(t0_ovf), .sent(sent));
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  // sticky record of any watchdog pulse, so a one-cycle pulse is never missed
  always @(posedge clk) wd_seen <= sys_rst ? 1'b0 : (wd_seen | (wd === 1'b1));
  task chk(input logic [7:0] g, input logic [7:0] e);
    check_count++;
    if (g !== e) begin
      n_fail++;
      $display("Error %0t: got %h want %h", $time, g, e);
    end
  endtask
  // one write, strobe high for a single edge
  task wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk);
    sfr_addr = a;
    sfr_wdata = d;
    sfr_wr = 1'b1;
    @(negedge clk);
    sfr_wr = 1'b0;
  endtask
  // read data is registered, so look one cycle after the read edge
  task rd(input logic [7:0] a, input logic [7:0] e);
    @(negedge clk);
    sfr_addr = a;
    sfr_rd = 1'b1;
    @(negedge clk);
    sfr_rd = 1'b0;
    @(negedge clk);
    chk(sfr_rdata_r, e);
  endtask
  task edges(input int n);
    for (i = 0; i < n; i++) begin
      ext_in = ~ext_in;
      repeat (4) @(negedge clk);
    end
  endtask
  task test_done;
    $display("checks %0d mismatches %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  initial begin
    {sys_rst, sfr_wr, sfr_rd, cpu_idle, ext_in, t0_en} = 6'h20;
    sfr_addr = 8'h00;
    sfr_wdata = 8'h00;
    pin_in = 5'h1f;
    repeat (8) @(negedge clk);
    sys_rst = 1'b0;
    rd(8'hd9, 8'h00);
    rd(8'h00, 8'h00);
    chk({3'h0, module_pin_r}, 8'h1f);
    $display("test reset done");
    // pin edges while stopped must not count, then five rising edges once each
    wr(8'hd9, 8'h06);
    edges(4);
    rd(8'he9, 8'h00);
    wr(8'hd8, 8'h40);
    edges(10);
    rd(8'he9, 8'h05);
    chk({2'h0, pin_claim_r}, 8'h01);
    wr(8'hd9, 8'h04);
    t0_en = 1'b1;
    repeat (30) @(negedge clk);
    t0_en = 1'b0;
    repeat (4) @(negedge clk);
    rd(8'he9, 8'h05 + sent);
    $display("test sources done");
    // wrap from all ones sets the sticky overflow flag
    wr(8'hd8, 8'h00);
    wr(8'he9, 8'hfe);
    wr(8'hf9, 8'hff);
    wr(8'hd9, 8'h03);
    wr(8'hd8, 8'h40);
    repeat (20) @(negedge clk);
    chk({7'h0, irq_r}, 8'h01);
    rd(8'hd8, 8'hc0);
    wr(8'hd8, 8'h00);
    repeat (3) @(negedge clk);
    chk({7'h0, irq_r}, 8'h00);
    // timer on module 0, toggle on module 1, no compare enable on module 2
    wr(8'he9, 8'h00);
    for (i = 0; i < 3; i++) begin
      wr(8'hea + i[7:0], 8'h05);
      wr(8'hfa + i[7:0], 8'h00);
    end
    wr(8'hda, 8'h49);
    wr(8'hdb, 8'h4c);
    wr(8'hdc, 8'h0c);
    wr(8'hd9, 8'h02);
    wr(8'hd8, 8'h40);
    repeat (24) @(negedge clk);
    rd(8'hd8, 8'h43);
    chk({7'h0, irq_r}, 8'h01);
    chk({3'h0, module_pin_r}, 8'h1d);
    wr(8'hda, 8'h00);
    $display("test compare done");
    // falling then rising capture of a frozen count
    wr(8'hd8, 8'h00);
    wr(8'he9, 8'h34);
    wr(8'hf9, 8'h12);
    wr(8'hdd, 8'h10);
    pin_in = 5'h17;
    repeat (6) @(negedge clk);
    rd(8'hed, 8'h34);
    rd(8'hfd, 8'h12);
    rd(8'hd8, 8'h08);
    wr(8'he9, 8'h56);
    wr(8'hdd, 8'h20);
    pin_in = 5'h1f;
    repeat (6) @(negedge clk);
    rd(8'hed, 8'h56);
    $display("test capture done");
    // pwm on module 2: compare enable gates it, duty from low byte, reload at wrap
    wr(8'hfc, 8'h80);
    wr(8'hec, 8'h80);
    wr(8'he9, 8'h10);
    wr(8'hdc, 8'h02);
    repeat (3) @(negedge clk);
    chk({7'h0, module_pin_r[2]}, 8'h01);
    wr(8'hdc, 8'h42);
    repeat (3) @(negedge clk);
    chk({7'h0, module_pin_r[2]}, 8'h00);
    wr(8'he9, 8'h90);
    repeat (3) @(negedge clk);
    chk({7'h0, module_pin_r[2]}, 8'h01);
    wr(8'hfc, 8'h20);
    wr(8'he9, 8'hfe);
    wr(8'hd9, 8'h02);
    wr(8'hd8, 8'h40);
    repeat (12) @(negedge clk);
    rd(8'hec, 8'h20);
    chk({7'h0, module_pin_r[2]}, 8'h00);
    wr(8'hd8, 8'h00);
    $display("test pwm done");
    // idle with idle-stop holds the count, without idle-stop it runs on
    wr(8'he9, 8'h00);
    wr(8'hd9, 8'h80);
    cpu_idle = 1'b1;
    wr(8'hd8, 8'h40);
    repeat (30) @(negedge clk);
    rd(8'he9, 8'h00);
    wr(8'hd9, 8'h00);
    repeat (30) @(negedge clk);
    rd(8'he9, 8'h05);
    cpu_idle = 1'b0;
    $display("test idle done");
    // software keeps the module 4 value ahead, then lets the watchdog match
    wr(8'hd8, 8'h00);
    wr(8'hee, 8'h10);
    wr(8'hfe, 8'h00);
    wr(8'hde, 8'h40);
    wr(8'hf9, 8'h00);
    wr(8'he9, 8'h00);
    wr(8'hd9, 8'h42);
    wr(8'hd8, 8'h40);
    for (i = 0; i < 3; i++) begin
      repeat (8) @(negedge clk);
      wr(8'hfe, 8'h01 + i[7:0]);
    end
    chk({7'h0, wd_seen}, 8'h00);
    wr(8'hee, 8'h40);
    wr(8'hfe, 8'h00);
    for (i = 0; i < 600 && wd !== 1'b1; i++)
      @(negedge clk);
    chk({7'h0, wd}, 8'h01);
    $display("test watchdog done");
    test_done();
  end
endmodule // tb_top
